// File: design/ustlb_pkg.sv
package ustlb_pkg;
   // Register index and byte addresses (index times four)
   localparam logic [5:0] S2_INDEX       = 6'h05;
   localparam logic [5:0] S2_ADDR        = 6'h14;
   localparam logic [5:0] IRQ_STATUS_ADDR = 6'h18;
   localparam logic [5:0] IRQ_CLEAR_ADDR = 6'h1C;
   localparam logic [5:0] IRQ_ENABLE_ADDR = 6'h20;
   // Field positions of serial_status_control_two
   localparam int BRK_FLAG_BIT  = 7;
   localparam int EDGE_FLAG_BIT = 6;
   localparam int ORDER_BIT     = 5;
   localparam int INVERT_BIT    = 4;
   localparam int WAKE_IDLE_BIT = 3;
   localparam int TX_LONG_BIT   = 2;
   localparam int LBK_EN_BIT    = 1;
   localparam int RAF_BIT       = 0;
   // Interrupt status fields
   localparam int IRQ_BRK_BIT   = 0;
   localparam int IRQ_EDGE_BIT  = 1;
   localparam int IRQ_W         = 2;
   // Reset values
   localparam logic [7:0]       S2_RESET  = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
   // Break lengths in bit times, indexed by frame format
   localparam logic [3:0][4:0] DET_SHORT = {5'h0D, 5'h0C, 5'h0B, 5'h0A};
   localparam logic [3:0][4:0] DET_LONG  = {5'h0F, 5'h0E, 5'h0C, 5'h0B};
   localparam logic [3:0][4:0] TX_SHORT  = {5'h0D, 5'h0C, 5'h0B, 5'h0A};
   localparam logic [3:0][4:0] TX_LONG   = {5'h10, 5'h0F, 5'h0E, 5'h0D};
   // Highest data bit index of the shortest character
   localparam logic [3:0] MSB_BASE = 4'h7;
endpackage

// File: design/ustlb_rx_front.sv
`timescale 1ns/1ns
`default_nettype none
module ustlb_rx_front (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_resetn,
   // Pin and polarity
   input  wire logic i_rxd,
   input  wire logic i_invert,
   // Conditioned line
   output logic      o_line,
   output logic      o_active_edge
);
   logic sync_a;
   logic sync_b;
   logic line_prev;

   // Idle line is high, so the chain resets to mark
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
      end else begin
         sync_a <= i_rxd;
         sync_b <= sync_a;
      end
   end

   // Inversion ahead of every consumer of the line
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_line    <= 1'b1;
         line_prev <= 1'b1;
      end else begin
         o_line    <= sync_b ^ i_invert;
         line_prev <= o_line;
      end
   end

   // Falling edge of the corrected line is the active pin edge
   assign o_active_edge = line_prev & ~o_line;
endmodule // ustlb_rx_front
`default_nettype wire

// File: design/ustlb_break_det.sv
`timescale 1ns/1ns
`default_nettype none
module ustlb_break_det #(
   parameter int CNT_W = 5
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_resetn,
   // Line and timing
   input  wire logic             i_line,
   input  wire logic             i_bit_tick,
   input  wire logic [CNT_W-1:0] i_threshold,
   // Result
   output logic                  o_break
);
   logic [CNT_W-1:0] low_bits;
   logic             seen;

   if (CNT_W < 5) begin : g_chk
      $error("ustlb_break_det: CNT_W too small for break lengths");
   end

   // One report per break; the count saturates until the line returns high
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         low_bits <= '0;
         seen     <= 1'b0;
         o_break  <= 1'b0;
      end else if (i_line) begin
         low_bits <= '0;
         seen     <= 1'b0;
         o_break  <= 1'b0;
      end else begin
         o_break <= 1'b0;
         if (i_bit_tick && !seen) begin
            if (low_bits + 1'b1 >= i_threshold) begin
               seen    <= 1'b1;
               o_break <= 1'b1;
            end
            low_bits <= low_bits + 1'b1;
         end
      end
   end
endmodule // ustlb_break_det
`default_nettype wire

// File: design/ustlb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ustlb_top (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // Avalon-MM slave
   input  wire logic [5:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   // Serial pin
   input  wire logic        i_rxd,
   // From the rest of the UART
   input  wire logic        i_bit_tick,
   input  wire logic        i_nine_bit,
   input  wire logic        i_ten_bit_select,
   input  wire logic        i_parity_enable,
   input  wire logic        i_two_stop,
   input  wire logic        i_start_detect,
   input  wire logic        i_idle_detect,
   input  wire logic        i_receiver_standby,
   input  wire logic        i_frame_error_event,
   input  wire logic        i_receive_full_event,
   input  wire logic [9:0]  i_tx_data,
   input  wire logic [9:0]  i_rx_shift,
   // To the rest of the UART
   output logic             o_rx_line,
   output logic      [9:0]  o_tx_shift,
   output logic      [9:0]  o_rx_data,
   output logic      [4:0]  o_tx_break_bits,
   output logic             o_frame_error_set,
   output logic             o_receive_full_set,
   output logic             o_idle_set,
   output logic             o_receiver_active,
   output logic             o_irq
);
   localparam int IRQ_W = ustlb_pkg::IRQ_W;

   logic             break_detected_flag;
   logic             receive_edge_flag;
   logic             bit_order_reverse;
   logic             receive_polarity_invert;
   logic             wakeup_idle_report;
   logic             long_break_transmit;
   logic             long_break_detect_enable;
   logic             receiver_active_flag;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_enable;
   logic [7:0]       s2_value;
   logic [31:0]      next_readdata;
   logic [1:0]       fmt_idx;
   logic [4:0]       det_thresh;
   logic [3:0]       msb_idx;
   logic             active_edge;
   logic             line_raw;
   logic             break_seen;
   logic             break_event;
   logic             wr_go;
   logic             wr_s2;
   logic             wr_clear;
   logic             wr_enable;

   // Line conditioning and break detection
   ustlb_rx_front u_front (
      .i_clk         (i_clk),
      .i_resetn      (i_resetn),
      .i_rxd         (i_rxd),
      .i_invert      (receive_polarity_invert),
      .o_line        (line_raw),
      .o_active_edge (active_edge)
   );

   ustlb_break_det #(.CNT_W(5)) u_brk (
      .i_clk       (i_clk),
      .i_resetn    (i_resetn),
      .i_line      (line_raw),
      .i_bit_tick  (i_bit_tick),
      .i_threshold (det_thresh),
      .o_break     (break_seen)
   );

   assign o_rx_line   = line_raw;
   assign break_event = break_seen & long_break_detect_enable;

   // Frame format selects break lengths
   always_comb begin
      if (i_ten_bit_select) begin
         fmt_idx = i_two_stop ? 2'h3 : 2'h2;
      end else if (i_nine_bit && i_two_stop) begin
         fmt_idx = 2'h2;
      end else if (i_nine_bit || i_two_stop) begin
         fmt_idx = 2'h1;
      end else begin
         fmt_idx = 2'h0;
      end
   end

   always_comb begin
      if (long_break_detect_enable) begin
         det_thresh = ustlb_pkg::DET_LONG[fmt_idx];
      end else begin
         det_thresh = ustlb_pkg::DET_SHORT[fmt_idx];
      end
   end

   // Highest data bit; parity keeps its own slot above it
   assign msb_idx = ustlb_pkg::MSB_BASE + {3'h0, i_nine_bit}
                  + {3'h0, i_ten_bit_select} - {3'h0, i_parity_enable};

   function automatic logic [9:0] ustlb_order(input logic [9:0] d,
                                              input logic [3:0] msb,
                                              input logic       rev);
      logic [9:0] r;
      r = d;
      for (int i = 0; i < 10; i++) begin
         if (rev && i <= int'(msb)) begin
            r[i] = d[int'(msb) - i];
         end
      end
      return r;
   endfunction

   // Avalon slave: one wait cycle, answer in the next
   assign wr_go     = i_avs_write & ~o_avs_waitrequest;
   assign wr_s2     = wr_go & i_avs_byteenable[0]
                    & (i_avs_address == ustlb_pkg::S2_ADDR);
   assign wr_clear  = wr_go & i_avs_byteenable[0]
                    & (i_avs_address == ustlb_pkg::IRQ_CLEAR_ADDR);
   assign wr_enable = wr_go & i_avs_byteenable[0]
                    & (i_avs_address == ustlb_pkg::IRQ_ENABLE_ADDR);

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_avs_waitrequest <= 1'b1;
      end else begin
         o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
      end
   end

   assign s2_value = {break_detected_flag, receive_edge_flag, bit_order_reverse,
                      receive_polarity_invert, wakeup_idle_report,
                      long_break_transmit, long_break_detect_enable,
                      receiver_active_flag};

   // Clear register reads as zero, unmapped addresses too
   always_comb begin
      case (i_avs_address)
         ustlb_pkg::S2_ADDR:         next_readdata = {24'h000000, s2_value};
         ustlb_pkg::IRQ_STATUS_ADDR: next_readdata = {30'h0, irq_status};
         ustlb_pkg::IRQ_ENABLE_ADDR: next_readdata = {30'h0, irq_enable};
         default:                    next_readdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_avs_readdata <= 32'h00000000;
      end else if (i_avs_read && o_avs_waitrequest) begin
         o_avs_readdata <= next_readdata;
      end
   end

   // Control bits; order and idle bits assume software quiesced the unit
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         bit_order_reverse        <= ustlb_pkg::S2_RESET[ustlb_pkg::ORDER_BIT];
         receive_polarity_invert  <= ustlb_pkg::S2_RESET[ustlb_pkg::INVERT_BIT];
         wakeup_idle_report       <= ustlb_pkg::S2_RESET[ustlb_pkg::WAKE_IDLE_BIT];
         long_break_transmit      <= ustlb_pkg::S2_RESET[ustlb_pkg::TX_LONG_BIT];
         long_break_detect_enable <= ustlb_pkg::S2_RESET[ustlb_pkg::LBK_EN_BIT];
      end else if (wr_s2) begin
         bit_order_reverse        <= i_avs_writedata[ustlb_pkg::ORDER_BIT];
         receive_polarity_invert  <= i_avs_writedata[ustlb_pkg::INVERT_BIT];
         wakeup_idle_report       <= i_avs_writedata[ustlb_pkg::WAKE_IDLE_BIT];
         long_break_transmit      <= i_avs_writedata[ustlb_pkg::TX_LONG_BIT];
         long_break_detect_enable <= i_avs_writedata[ustlb_pkg::LBK_EN_BIT];
      end
   end

   // Write-one-to-clear flags; a same-cycle event wins over the clear
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         break_detected_flag <= ustlb_pkg::S2_RESET[ustlb_pkg::BRK_FLAG_BIT];
      end else if (break_event) begin
         break_detected_flag <= 1'b1;
      end else if (wr_s2 && i_avs_writedata[ustlb_pkg::BRK_FLAG_BIT]) begin
         break_detected_flag <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         receive_edge_flag <= ustlb_pkg::S2_RESET[ustlb_pkg::EDGE_FLAG_BIT];
      end else if (active_edge) begin
         receive_edge_flag <= 1'b1;
      end else if (wr_s2 && i_avs_writedata[ustlb_pkg::EDGE_FLAG_BIT]) begin
         receive_edge_flag <= 1'b0;
      end
   end

   // Start of a new frame outranks an idle seen in the same cycle
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         receiver_active_flag <= ustlb_pkg::S2_RESET[ustlb_pkg::RAF_BIT];
      end else if (i_start_detect) begin
         receiver_active_flag <= 1'b1;
      end else if (i_idle_detect) begin
         receiver_active_flag <= 1'b0;
      end
   end

   // Interrupt status, clear and enable
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         irq_status <= ustlb_pkg::IRQ_RESET;
      end else begin
         irq_status <= (irq_status & ~({IRQ_W{wr_clear}} & i_avs_writedata[IRQ_W-1:0]))
                     | {active_edge, break_event};
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         irq_enable <= ustlb_pkg::IRQ_RESET;
      end else if (wr_enable) begin
         irq_enable <= i_avs_writedata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_status & irq_enable);
      end
   end

   // Flag gating toward the receiver core
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_frame_error_set  <= 1'b0;
         o_receive_full_set <= 1'b0;
         o_idle_set         <= 1'b0;
         o_receiver_active  <= 1'b0;
      end else begin
         o_frame_error_set  <= i_frame_error_event & ~long_break_detect_enable;
         o_receive_full_set <= i_receive_full_event & ~long_break_detect_enable;
         o_idle_set         <= i_idle_detect
                             & (~i_receiver_standby | wakeup_idle_report);
         o_receiver_active  <= receiver_active_flag;
      end
   end

   // Data ordering and transmit break length
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_tx_shift      <= 10'h000;
         o_rx_data       <= 10'h000;
         o_tx_break_bits <= ustlb_pkg::TX_SHORT[0];
      end else begin
         o_tx_shift      <= ustlb_order(i_tx_data, msb_idx, bit_order_reverse);
         o_rx_data       <= ustlb_order(i_rx_shift, msb_idx, bit_order_reverse);
         o_tx_break_bits <= long_break_transmit ? ustlb_pkg::TX_LONG[fmt_idx]
                                                : ustlb_pkg::TX_SHORT[fmt_idx];
      end
   end

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   a_brk_flag_set: assert property (break_event |=> break_detected_flag)
      else $error("break flag not set");
   a_brk_w1c: assert property (wr_s2 && i_avs_writedata[ustlb_pkg::BRK_FLAG_BIT]
      && !break_event |=> !break_detected_flag)
      else $error("break flag not cleared");
   a_edge_flag_set: assert property ($fell(line_raw) |=> receive_edge_flag)
      else $error("edge flag missed");
   a_edge_flag_hold: assert property (receive_edge_flag
      && !(wr_s2 && i_avs_writedata[ustlb_pkg::EDGE_FLAG_BIT]) |=> receive_edge_flag)
      else $error("edge flag dropped");
   a_fe_gated: assert property (long_break_detect_enable
      |=> !o_frame_error_set && !o_receive_full_set)
      else $error("flag passed during long break");
   a_idle_hidden: assert property (i_idle_detect && i_receiver_standby
      && !wakeup_idle_report |=> !o_idle_set)
      else $error("idle reported in standby");
   a_idle_reported: assert property (i_idle_detect && i_receiver_standby
      && wakeup_idle_report |=> o_idle_set)
      else $error("idle not reported");
   a_order_plain: assert property (!bit_order_reverse |=> o_rx_data == $past(i_rx_shift))
      else $error("plain order altered data");
   a_raf_start: assert property (i_start_detect
      |=> receiver_active_flag ##1 o_receiver_active)
      else $error("active flag not set");
   a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("bus answer timing wrong");

   c_break_seen: cover property (break_event ##1 break_detected_flag);
   c_edge_irq: cover property (active_edge ##[1:4] o_irq);
   c_msb_first: cover property (bit_order_reverse && i_parity_enable);
endmodule // ustlb_top
`default_nettype wire

// File: verif/ustlb_lin_node.sv
`timescale 1ns/1ns
`default_nettype none
module ustlb_lin_node (
   // Clock and baud
   input  wire logic i_clk,
   input  wire logic i_bit_tick,
   // Polarity that the remote node drives with
   input  wire logic i_inverted,
   // Serial line
   output logic      o_rxd
);
   logic dominant = 1'b0;

   // Idle follows the polarity, so swapping polarity never looks like a break
   assign o_rxd = ~(dominant ^ i_inverted);

   // Dominant level for a whole number of bit times, a break when long enough
   task automatic hold(input int n);
      int k;
      k = 0;
      @(posedge i_clk);
      dominant <= 1'b1;
      while (k < n) begin
         @(posedge i_clk);
         if (i_bit_tick === 1'b1) begin
            k++;
         end
      end
      dominant <= 1'b0;
   endtask
endmodule // ustlb_lin_node
`default_nettype wire

// File: verif/uart_status_two_lin_break_bits_tb.sv
`timescale 1ns/1ns
`default_nettype none
module uart_status_two_lin_break_bits_tb;
   logic        i_clk = 1'b0;
   logic        i_resetn;
   logic [5:0]  i_avs_address;
   logic        i_avs_read;
   logic        i_avs_write;
   logic [31:0] i_avs_writedata;
   logic [31:0] o_avs_readdata;
   logic        o_avs_waitrequest;
   logic        rxd, tick, inv, nine, ten, par, two, standby, rx_line, irq, rx_act;
   logic [3:0]  ev;
   logic [2:0]  ev_out;
   logic [9:0]  tx, rxs, tx_sh, rx_dat;
   logic [4:0]  brk_bits;
   logic [1:0]  tick_cnt;
   logic [31:0] q;
   logic [2:0]  got;
   int          errors;
   int          tests_run;

   ustlb_top dut (
      .i_clk(i_clk), .i_resetn(i_resetn),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hF),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
      .i_rxd(rxd), .i_bit_tick(tick), .i_nine_bit(nine), .i_ten_bit_select(ten),
      .i_parity_enable(par), .i_two_stop(two), .i_start_detect(ev[3]),
      .i_idle_detect(ev[2]), .i_receiver_standby(standby), .i_frame_error_event(ev[1]),
      .i_receive_full_event(ev[0]), .i_tx_data(tx), .i_rx_shift(rxs),
      .o_rx_line(rx_line), .o_tx_shift(tx_sh), .o_rx_data(rx_dat),
      .o_tx_break_bits(brk_bits), .o_frame_error_set(ev_out[1]),
      .o_receive_full_set(ev_out[0]), .o_idle_set(ev_out[2]),
      .o_receiver_active(rx_act), .o_irq(irq)
   );

   ustlb_lin_node node (
      .i_clk(i_clk), .i_bit_tick(tick), .i_inverted(inv), .o_rxd(rxd)
   );

   always #2 i_clk = ~i_clk;

   // Free running bit tick, one bit time every four clocks
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         tick_cnt <= 2'h0;
         tick     <= 1'b0;
      end else begin
         tick_cnt <= tick_cnt + 2'h1;
         tick     <= (tick_cnt == 2'h3);
      end
   end

   task automatic final_report;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         errors++;
      end
   endtask

   // One bus cycle; request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      i_avs_address   <= a;
      i_avs_writedata <= d;
      i_avs_write     <= w;
      i_avs_read      <= ~w;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 20);
      q = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read  <= 1'b0;
      if (n >= 20) begin
         errors++;
         final_report();
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask

   // Pulse receiver events for one cycle and take the registered answers
   task automatic pulse(input logic [3:0] m);
      @(posedge i_clk);
      ev <= m;
      @(posedge i_clk);
      ev <= 4'h0;
      @(posedge i_clk);
      got = ev_out;
   endtask

   task automatic settle;
      repeat (8) @(posedge i_clk);
   endtask

   logic [9:0] ord_fmt [4] = '{10'h000, 10'h004, 10'h006, 10'h001};
   logic [9:0] ord_in  [4] = '{10'h001, 10'h001, 10'h001, 10'h381};
   logic [9:0] ord_exp [4] = '{10'h080, 10'h100, 10'h200, 10'h3C0};
   int         det_long [2] = '{11, 15};
   logic [4:0] tx_long  [2] = '{5'h0D, 5'h10};

   initial begin
      i_resetn = 1'b0; i_avs_address = 6'h00; i_avs_read = 1'b0;
      i_avs_write = 1'b0; i_avs_writedata = 32'h0;
      inv = 1'b0; nine = 1'b0; ten = 1'b0; par = 1'b0; two = 1'b0; standby = 1'b0;
      ev = 4'h0; tx = 10'h000; rxs = 10'h000; errors = 0; tests_run = 0;
      repeat (3) @(posedge i_clk);
      i_resetn <= 1'b1;
      @(posedge i_clk);
      rd(ustlb_pkg::S2_ADDR, 32'h0, 32'hFFFFFFFF);
      rd(ustlb_pkg::IRQ_ENABLE_ADDR, 32'h0, 32'hFFFFFFFF);
      rd(6'h3C, 32'h0, 32'hFFFFFFFF);
      chk(brk_bits, 32'h0A);
      // Falling edge, flag held through a zero write, masked then enabled interrupt
      node.hold(1);
      settle();
      rd(ustlb_pkg::S2_ADDR, 32'h40, 32'hC0);
      wr(ustlb_pkg::S2_ADDR, 32'h00);
      rd(ustlb_pkg::S2_ADDR, 32'h40, 32'hC0);
      rd(ustlb_pkg::IRQ_STATUS_ADDR, 32'h2, 32'h3);
      chk(irq, 32'h0);
      wr(ustlb_pkg::IRQ_ENABLE_ADDR, 32'h2);
      settle();
      chk(irq, 32'h1);
      wr(ustlb_pkg::S2_ADDR, 32'h40);
      rd(ustlb_pkg::S2_ADDR, 32'h00, 32'hC0);
      wr(ustlb_pkg::IRQ_CLEAR_ADDR, 32'h2);
      settle();
      chk(irq, 32'h0);
      rd(ustlb_pkg::IRQ_STATUS_ADDR, 32'h0, 32'h3);
      wr(ustlb_pkg::IRQ_ENABLE_ADDR, 32'h0);
      // Inverted line: idle stays idle, a rising pin edge is the active one
      wr(ustlb_pkg::S2_ADDR, 32'h10);
      inv <= 1'b1;
      settle();
      wr(ustlb_pkg::S2_ADDR, 32'hD0);
      rd(ustlb_pkg::S2_ADDR, 32'h10, 32'hFF);
      chk(rx_line, 32'h1);
      node.hold(1);
      settle();
      rd(ustlb_pkg::S2_ADDR, 32'h50, 32'hFF);
      wr(ustlb_pkg::S2_ADDR, 32'h00);
      inv <= 1'b0;
      settle();
      // Detection off: even a long low period never reports a break
      node.hold(13);
      settle();
      rd(ustlb_pkg::S2_ADDR, 32'h00, 32'h80);
      // Long detection: just below and above the raised threshold, shortest and longest formats
      for (int k = 0; k < 2; k++) begin
         ten <= k[0];
         two <= k[0];
         wr(ustlb_pkg::S2_ADDR, 32'hC6);
         settle();
         chk(brk_bits, tx_long[k]);
         node.hold(det_long[k] - 1);
         settle();
         rd(ustlb_pkg::S2_ADDR, 32'h02, 32'h82);
         node.hold(det_long[k] + 1);
         settle();
         rd(ustlb_pkg::S2_ADDR, 32'h82, 32'h82);
         pulse(4'h3);
         chk(got, 32'h0);
      end
      wr(ustlb_pkg::S2_ADDR, 32'hC0);
      rd(ustlb_pkg::S2_ADDR, 32'h00, 32'h82);
      ten <= 1'b0;
      two <= 1'b0;
      pulse(4'h3);
      chk(got, 32'h3);
      // Waking idle character in standby
      standby <= 1'b1;
      pulse(4'h4);
      chk(got, 32'h0);
      wr(ustlb_pkg::S2_ADDR, 32'h08); // receiver held off meanwhile
      pulse(4'h4);
      chk(got, 32'h4);
      standby <= 1'b0;
      // Receiver active follows start and idle line
      pulse(4'h8);
      rd(ustlb_pkg::S2_ADDR, 32'h01, 32'h01);
      chk(rx_act, 32'h1);
      pulse(4'h4);
      rd(ustlb_pkg::S2_ADDR, 32'h00, 32'h01);
      chk(rx_act, 32'h0);
      // Bit order, changed only between frames
      wr(ustlb_pkg::S2_ADDR, 32'h00);
      rxs <= 10'h001;
      tx  <= 10'h0A1;
      settle();
      chk({rx_dat, tx_sh}, {10'h001, 10'h0A1});
      wr(ustlb_pkg::S2_ADDR, 32'h20);
      settle();
      chk(tx_sh, 32'h085);
      for (int k = 0; k < 4; k++) begin
         nine <= ord_fmt[k][2];
         ten  <= ord_fmt[k][1];
         par  <= ord_fmt[k][0];
         rxs  <= ord_in[k];
         settle();
         chk(rx_dat, ord_exp[k]);
      end
      final_report();
   end

   initial begin
      repeat (60000) @(posedge i_clk);
      errors++;
      final_report();
   end
endmodule // uart_status_two_lin_break_bits_tb
`default_nettype wire
